// ==== include/ioct_consts.vh ====
`ifndef IOCT_CONSTS_VH
`define IOCT_CONSTS_VH
// ****************************************
// register word indices (word address)
// ****************************************
`define IOCT_A_DIN_ONE    6'h00
`define IOCT_A_DIN_ALL    6'h01
`define IOCT_A_DOUT_ALL   6'h02
`define IOCT_A_DOUT_HIGH  6'h03
`define IOCT_A_DOUT_LOW   6'h04
`define IOCT_A_CNT_EN     6'h05
`define IOCT_A_CNT_CLR    6'h06
`define IOCT_A_CNT_LAT    6'h07
`define IOCT_A_LATCH1     6'h08
`define IOCT_A_LATCH2     6'h09
`define IOCT_A_TRIG       6'h0a
`define IOCT_A_MUX        6'h0b
`define IOCT_A_ADC_CTRL   6'h0c
`define IOCT_A_ADC_STAT   6'h0d
`define IOCT_A_ADC_DATA   6'h0e
`define IOCT_A_SEQ_SEL    6'h0f
`define IOCT_A_SEQ_READ   6'h10
`define IOCT_A_DAC1       6'h11
`define IOCT_A_DAC2       6'h12
// ****************************************
// field positions and values
// ****************************************
`define IOCT_CNT1_BIT     0
`define IOCT_CNT2_BIT     1
`define IOCT_CLK1_LINE    4
`define IOCT_CLK2_LINE    5
`define IOCT_CTRL_START   0
`define IOCT_CTRL_FAST    1
`define IOCT_CODE_MAX     16'hffff
`define IOCT_CODE_MIN     16'h0000
`define IOCT_DAC_RESET    16'h8000
`define IOCT_NS_PER_CLK   10
`define IOCT_SETTLE_NS    6500
`define IOCT_CONV_NS      10000
`define IOCT_FAST_NS      2000
`endif

// ==== verilog/ioct_top.v ====
// Functional notes
// - six digital inputs and six digital outputs, numbered zero to five
// - inputs four and five clock the counters and stay readable
// - rising edge on trigger input raises a process start event
// - read one selected input, or all inputs as one word
// - write all outputs, or force one output high or low alone
// - two 32-bit counters, configured and read singly or together
// - each counter increments on every rising edge of its clock
// - each counter has a latch captured on software command
// - shared control words enable, clear and latch the counters
// - eight differential inputs muxed into one 16-bit converter, logic selects
// - channels addressed by odd numbers one to fifteen; logic selects channel 0 to 7 from low three bits
// - conversion starts only after mux settling time following a change
// - software may select fast conversion time instead of standard
// - sequence mode converts selected channels in turn, results read back; the first start after a channel register write converts that channel only
// - codes are offset binary, zero most negative, 65535 most positive
// - results and output values sit in low 16 bits of 32-bit word
// - out-of-range output values saturate to maximum or minimum code
// - bit 0 is counter one, bit 1 counter two; one acts
// - clear and latch are self-clearing pulses, enable holds until rewritten
//
// Design decisions made here: the strobed register port and the register addresses.
`include "ioct_consts.vh"
module ioct_top #(
   parameter N_DIO    = 6,
   parameter CNT_W    = 32,
   parameter N_CH     = 8,
   parameter SETTLE_C = (`IOCT_SETTLE_NS + `IOCT_NS_PER_CLK - 1) / `IOCT_NS_PER_CLK,
   parameter CONV_C   = (`IOCT_CONV_NS + `IOCT_NS_PER_CLK - 1) / `IOCT_NS_PER_CLK,
   parameter FAST_C   = (`IOCT_FAST_NS + `IOCT_NS_PER_CLK - 1) / `IOCT_NS_PER_CLK
) (
   input  wire             i_clk,
   input  wire             i_rstn,
   input  wire [5:0]       i_addr,
   input  wire [31:0]      i_wdata,
   input  wire             i_wr,
   input  wire             i_rd,
   output reg  [31:0]      o_rdata,
   input  wire [N_DIO-1:0] i_din,
   output reg  [N_DIO-1:0] o_dout,
   input  wire             i_trig,
   output reg              o_trig_event,
   output reg  [2:0]       o_mux_sel,
   output reg              o_adc_start,
   input  wire             i_adc_done,
   input  wire [15:0]      i_adc_data,
   output reg  [15:0]      o_dac1,
   output reg  [15:0]      o_dac2
);
   // ****************************************
   // helpers
   // ****************************************
   // signed 32-bit word clamped to 16-bit code range
   function [15:0] sat16;
      input [31:0] v;
      begin
         if (v[31])
            sat16 = `IOCT_CODE_MIN;
         else if (|v[30:16])
            sat16 = `IOCT_CODE_MAX;
         else
            sat16 = v[15:0];
      end
   endfunction
   function hit;
      input [5:0] a;
      begin
         hit = (i_addr == a);
      end
   endfunction

   // ****************************************
   // states
   // ****************************************
   localparam [1:0] S_IDLE   = 2'h0;
   localparam [1:0] S_SETTLE = 2'h1;
   localparam [1:0] S_CONV   = 2'h2;
   localparam [1:0] S_NEXT   = 2'h3;

   reg  [N_DIO-1:0] din_ff;
   reg              trig_ff;
   reg  [1:0]       cnt_en_ff;
   reg  [1:0]       cclk_ff;
   reg  [CNT_W-1:0] cnt_ff   [0:1];
   reg  [CNT_W-1:0] latch_ff [0:1];
   reg  [15:0]      adc_ff;
   reg  [15:0]      res_ff   [0:N_CH-1];
   reg  [N_CH-1:0]  seq_sel_ff;
   reg  [N_CH-1:0]  seq_todo_ff;
   reg              seq_ff;
   reg              fast_ff;
   reg              busy_ff;
   reg  [1:0]       st_ff;
   reg  [15:0]      tmr_ff;
   reg  [2:0]       rd_ptr_ff;
   reg  [2:0]       sel_ff;
   reg  [2:0]       nxt_ch;
   reg              nxt_found;
   integer          k;

   wire wr_cnt_en  = i_wr & hit(`IOCT_A_CNT_EN);
   wire wr_cnt_clr = i_wr & hit(`IOCT_A_CNT_CLR);
   wire wr_cnt_lat = i_wr & hit(`IOCT_A_CNT_LAT);
   wire wr_mux     = i_wr & hit(`IOCT_A_MUX);
   wire wr_ctrl    = i_wr & hit(`IOCT_A_ADC_CTRL);
   wire wr_dout    = i_wr & hit(`IOCT_A_DOUT_ALL);
   wire wr_high    = i_wr & hit(`IOCT_A_DOUT_HIGH) & (i_wdata[2:0] < N_DIO);
   wire wr_low     = i_wr & hit(`IOCT_A_DOUT_LOW) & (i_wdata[2:0] < N_DIO);
   wire wr_dac1    = i_wr & hit(`IOCT_A_DAC1);
   wire wr_dac2    = i_wr & hit(`IOCT_A_DAC2);
   wire wr_seq     = i_wr & hit(`IOCT_A_SEQ_SEL);
   // start refused while busy: a running sequence cannot be restarted
   wire start      = wr_ctrl & i_wdata[`IOCT_CTRL_START] & ~busy_ff;
   wire [15:0] conv_len = fast_ff ? FAST_C[15:0] : CONV_C[15:0];

   // ****************************************
   // digital i/o and trigger
   // ****************************************
   always @(posedge i_clk) begin
      if (!i_rstn) begin
         din_ff       <= {N_DIO{1'b0}};
         o_dout       <= {N_DIO{1'b0}};
         // event pin idles high behind its pull-up: no false edge after reset
         trig_ff      <= 1'b1;
         o_trig_event <= 1'b0;
      end else begin
         din_ff       <= i_din;
         trig_ff      <= i_trig;
         o_trig_event <= i_trig & ~trig_ff;
         if (wr_dout)
            o_dout <= i_wdata[N_DIO-1:0];
         else if (wr_high)
            o_dout[i_wdata[2:0]] <= 1'b1;
         else if (wr_low)
            o_dout[i_wdata[2:0]] <= 1'b0;
      end
   end

   // ****************************************
   // event counters
   // ****************************************
   // edge taken from registered input line, so line stays a plain input too
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_cnt
         always @(posedge i_clk) begin
            if (!i_rstn) begin
               cclk_ff[g]  <= 1'b0;
               cnt_ff[g]   <= {CNT_W{1'b0}};
               latch_ff[g] <= {CNT_W{1'b0}};
               cnt_en_ff[g] <= 1'b0;
            end else begin
               cclk_ff[g] <= din_ff[`IOCT_CLK1_LINE + g];
               if (wr_cnt_en)
                  cnt_en_ff[g] <= i_wdata[g];
               // clear wins over a count edge in the same cycle
               if (wr_cnt_clr & i_wdata[g])
                  cnt_ff[g] <= {CNT_W{1'b0}};
               else if (cnt_en_ff[g] & din_ff[`IOCT_CLK1_LINE + g] & ~cclk_ff[g])
                  cnt_ff[g] <= cnt_ff[g] + 1'b1;
               if (wr_cnt_lat & i_wdata[g])
                  latch_ff[g] <= cnt_ff[g];
            end
         end
      end
   endgenerate

   // ****************************************
   // converter sequencer
   // ****************************************
   // lowest pending channel is converted first
   always @* begin
      nxt_ch    = 3'h0;
      nxt_found = 1'b0;
      for (k = N_CH - 1; k >= 0; k = k - 1)
         if (seq_todo_ff[k]) begin
            nxt_ch    = k[2:0];
            nxt_found = 1'b1;
         end
   end

   always @(posedge i_clk) begin
      if (!i_rstn) begin
         st_ff       <= S_IDLE;
         busy_ff     <= 1'b0;
         tmr_ff      <= 16'h0000;
         o_mux_sel   <= 3'h0;
         sel_ff      <= 3'h0;
         o_adc_start <= 1'b0;
         adc_ff      <= 16'h0000;
         seq_sel_ff  <= {N_CH{1'b0}};
         seq_todo_ff <= {N_CH{1'b0}};
         seq_ff      <= 1'b0;
         fast_ff     <= 1'b0;
         // mid-scale code: outputs sit at zero volts after reset
         o_dac1      <= `IOCT_DAC_RESET;
         o_dac2      <= `IOCT_DAC_RESET;
      end else begin
         o_adc_start <= 1'b0;
         if (wr_dac1)
            o_dac1 <= sat16(i_wdata);
         if (wr_dac2)
            o_dac2 <= sat16(i_wdata);
         if (wr_seq)
            seq_sel_ff <= i_wdata[N_CH-1:0];
         if (wr_ctrl)
            fast_ff <= i_wdata[`IOCT_CTRL_FAST];
         // channel register ignored while busy: keeps mux stable mid-conversion
         if (wr_mux & ~busy_ff) begin
            o_mux_sel <= i_wdata[2:0];
            tmr_ff    <= SETTLE_C[15:0];
            st_ff     <= S_SETTLE;
         end else case (st_ff)
            S_IDLE: begin
               if (start) begin
                  busy_ff     <= 1'b1;
                  seq_ff      <= |seq_sel_ff;
                  seq_todo_ff <= seq_sel_ff;
                  st_ff       <= (|seq_sel_ff) ? S_NEXT : S_CONV;
                  o_adc_start <= ~(|seq_sel_ff);
                  tmr_ff      <= conv_len;
               end
            end
            S_SETTLE: begin
               // start taken at any point of settling, held until settled
               if (start) begin
                  busy_ff <= 1'b1;
                  seq_ff  <= 1'b0;
               end
               if (tmr_ff > 16'h0001)
                  tmr_ff <= tmr_ff - 16'h0001;
               else if (busy_ff) begin
                  o_adc_start <= 1'b1;
                  tmr_ff      <= conv_len;
                  st_ff       <= S_CONV;
               end else
                  tmr_ff <= 16'h0000;
            end
            S_CONV: begin
               if (tmr_ff != 16'h0000)
                  tmr_ff <= tmr_ff - 16'h0001;
               if (i_adc_done & (tmr_ff == 16'h0000)) begin
                  adc_ff         <= i_adc_data;
                  res_ff[sel_ff] <= i_adc_data;
                  st_ff          <= seq_ff ? S_NEXT : S_IDLE;
                  busy_ff        <= seq_ff;
               end
            end
            S_NEXT: begin
               if (nxt_found) begin
                  o_mux_sel            <= nxt_ch;
                  sel_ff               <= nxt_ch;
                  seq_todo_ff[nxt_ch]  <= 1'b0;
                  tmr_ff               <= SETTLE_C[15:0];
                  st_ff                <= S_SETTLE;
               end else begin
                  busy_ff <= 1'b0;
                  seq_ff  <= 1'b0;
                  st_ff   <= S_IDLE;
               end
            end
            default: st_ff <= S_IDLE;
         endcase
         if (wr_mux & ~busy_ff)
            sel_ff <= i_wdata[2:0];
      end
   end

   // ****************************************
   // register read port
   // ****************************************
   always @(posedge i_clk) begin
      if (!i_rstn) begin
         o_rdata   <= 32'h00000000;
         rd_ptr_ff <= 3'h0;
      end else begin
         o_rdata <= 32'h00000000;
         if (start)
            rd_ptr_ff <= 3'h0;
         if (i_rd) begin
            case (i_addr)
               `IOCT_A_DIN_ONE:  o_rdata <= {31'h0, din_ff[i_wdata[2:0] % N_DIO]};
               `IOCT_A_DIN_ALL:  o_rdata <= {{(32-N_DIO){1'b0}}, din_ff};
               `IOCT_A_DOUT_ALL: o_rdata <= {{(32-N_DIO){1'b0}}, o_dout};
               `IOCT_A_CNT_EN:   o_rdata <= {30'h0, cnt_en_ff};
               `IOCT_A_LATCH1:   o_rdata <= latch_ff[0];
               `IOCT_A_LATCH2:   o_rdata <= latch_ff[1];
               `IOCT_A_MUX:      o_rdata <= {29'h0, o_mux_sel};
               `IOCT_A_ADC_CTRL: o_rdata <= {30'h0, fast_ff, 1'b0};
               `IOCT_A_ADC_STAT: o_rdata <= {31'h0, busy_ff};
               `IOCT_A_ADC_DATA: o_rdata <= {16'h0000, adc_ff};
               `IOCT_A_SEQ_SEL:  o_rdata <= {{(32-N_CH){1'b0}}, seq_sel_ff};
               `IOCT_A_SEQ_READ: begin
                  o_rdata   <= {16'h0000, res_ff[rd_ptr_ff]};
                  rd_ptr_ff <= rd_ptr_ff + 3'h1;
               end
               `IOCT_A_DAC1:     o_rdata <= {16'h0000, o_dac1};
               `IOCT_A_DAC2:     o_rdata <= {16'h0000, o_dac2};
               // unmapped words read as zero
               default:          o_rdata <= 32'h00000000;
            endcase
         end
      end
   end
endmodule

// ==== testbench/ioct_asserts.sv ====
`include "ioct_consts.vh"
// ****************************************
// port checker
// ****************************************
module ioct_asserts #(
   parameter SETTLE_C = 4
) (
   input wire        i_clk,
   input wire        i_rstn,
   input wire [5:0]  i_addr,
   input wire [31:0] i_wdata,
   input wire        i_wr,
   input wire        i_rd,
   input wire [31:0] o_rdata,
   input wire [5:0]  i_din,
   input wire [5:0]  o_dout,
   input wire        i_trig,
   input wire        o_trig_event,
   input wire [2:0]  o_mux_sel,
   input wire        o_adc_start,
   input wire [15:0] o_dac1
);
   timeunit 1ns;
   timeprecision 1ns;
   reg [2:0]  mux_q_ff;
   reg [15:0] since_ff;
   // saturates so an idle start never looks early
   wire [15:0] nxt_since = (o_mux_sel != mux_q_ff) ? 16'h0 :
                           ((since_ff == 16'hffff) ? since_ff : since_ff + 16'h1);
   always @(posedge i_clk) begin
      mux_q_ff <= o_mux_sel;
      since_ff <= i_rstn ? nxt_since : 16'hffff;
   end
   function [15:0] sat(input [31:0] v);
      sat = v[31] ? 16'h0 : ((|v[30:16]) ? 16'hffff : v[15:0]);
   endfunction
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   sequence s_trig_rise;
      $rose(i_trig) ##0 $past(i_rstn);
   endsequence
   sequence s_rd(logic [5:0] a);
      i_rd && i_addr == a ##0 $stable(i_din);
   endsequence
   a_trig_event: assert property (s_trig_rise |=> o_trig_event)
      else $error("trigger event missing");
   a_trig_once: assert property (o_trig_event |=> !o_trig_event)
      else $error("trigger event too long");
   a_din_word: assert property (s_rd(`IOCT_A_DIN_ALL) |=> o_rdata == {26'h0, $past(i_din)})
      else $error("input word wrong");
   a_din_one: assert property (s_rd(`IOCT_A_DIN_ONE) ##0 i_wdata[2:0] < 3'd6
      |=> o_rdata == {31'h0, $past(i_din[i_wdata[2:0]])}) else $error("input bit wrong");
   a_dout_word: assert property (i_wr && i_addr == `IOCT_A_DOUT_ALL
      |=> o_dout == $past(i_wdata[5:0])) else $error("output word wrong");
   a_force_high: assert property (i_wr && i_addr == `IOCT_A_DOUT_HIGH && i_wdata[2:0] < 3'd6
      |=> o_dout == ($past(o_dout) | (6'h1 << $past(i_wdata[2:0])))) else $error("force high");
   a_force_low: assert property (i_wr && i_addr == `IOCT_A_DOUT_LOW && i_wdata[2:0] < 3'd6
      |=> o_dout == ($past(o_dout) & ~(6'h1 << $past(i_wdata[2:0])))) else $error("force low");
   a_dout_hold: assert property (!i_wr |=> $stable(o_dout))
      else $error("outputs moved");
   a_dac_sat: assert property (i_wr && i_addr == `IOCT_A_DAC1
      |=> o_dac1 == sat($past(i_wdata))) else $error("dac code wrong");
   a_start_pulse: assert property (o_adc_start |=> !o_adc_start)
      else $error("start too long");
   a_mux_settle: assert property (o_adc_start |-> since_ff >= SETTLE_C - 1)
      else $error("start before settling");
endmodule
bind ioct_top ioct_asserts #(.SETTLE_C(SETTLE_C)) u_chk (.i_clk, .i_rstn, .i_addr, .i_wdata,
   .i_wr, .i_rd, .o_rdata, .i_din, .o_dout, .i_trig, .o_trig_event, .o_mux_sel, .o_adc_start,
   .o_dac1);

// ==== testbench/ioct_adc_model.sv ====
// ****************************************
// converter model
// ****************************************
module ioct_adc_model (
   input  wire        i_clk,
   input  wire        i_start,
   input  wire [2:0]  i_mux,
   input  wire        i_slow,
   output reg         o_done = 1'b0,
   output reg  [15:0] o_data = 16'h5a5a
);
   timeunit 1ns;
   timeprecision 1ns;
   integer wait_n = -1;
   always @(posedge i_clk) begin
      if (i_start) begin
         o_done <= 1'b0;
         wait_n <= i_slow ? 20 : 1;
      end else if (wait_n > 0) begin
         wait_n <= wait_n - 1;
      end else if (wait_n == 0) begin
         o_done <= 1'b1;
         // offset binary: top channel full scale, bottom zero
         o_data <= (i_mux == 3'h7) ? 16'hffff : {i_mux, 13'h0};
         wait_n <= -1;
      end
      // no result held yet: data wanders so a stale capture shows
      if (!o_done && wait_n != 0 && !i_start) o_data <= ~o_data;
   end
endmodule

// ==== testbench/io_counters_and_trigger_tb.sv ====
`include "ioct_consts.vh"
// ****************************************
// bench top
// ****************************************
module io_counters_and_trigger_tb;
   timeunit 1ns;
   timeprecision 1ns;
   // event pin idles high, as its pull-up holds it
   reg         i_clk = 0, i_rstn = 0, i_wr = 0, i_rd = 0, i_trig = 1, slow = 1;
   reg  [5:0]  i_addr = 6'h0, i_din = 6'h0;
   reg  [31:0] i_wdata = 32'h0, d;
   wire [31:0] o_rdata;
   wire [5:0]  o_dout;
   wire [2:0]  o_mux_sel;
   wire [15:0] o_dac1, o_dac2, adc_data;
   wire        o_trig_event, o_adc_start, adc_done;
   integer     mismatches = 0, check_count = 0, trig_n = 0, k, w;
   // short settle and conversion counts keep the run brief
   ioct_top #(.SETTLE_C(4), .CONV_C(8), .FAST_C(3)) u_dut (.i_clk, .i_rstn, .i_addr,
      .i_wdata, .i_wr, .i_rd, .o_rdata, .i_din, .o_dout, .i_trig, .o_trig_event, .o_mux_sel,
      .o_adc_start, .i_adc_done(adc_done), .i_adc_data(adc_data), .o_dac1, .o_dac2);
   ioct_adc_model u_adc (.i_clk, .i_start(o_adc_start), .i_mux(o_mux_sel), .i_slow(slow),
      .o_done(adc_done), .o_data(adc_data));
   initial forever #5 i_clk = ~i_clk;
   always @(posedge i_clk) if (o_trig_event === 1'b1) trig_n <= trig_n + 1;
   task stop_test;
      if (mismatches == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task chk(input string n, input [31:0] e, input [31:0] g);
      check_count = check_count + 1;
      if (g !== e) begin
         mismatches = mismatches + 1;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   // every access leaves one idle edge so strobes never merge
   task wr(input [5:0] a, input [31:0] v);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= v;
      @(posedge i_clk);
      i_wr <= 1'b0;
      @(posedge i_clk);
   endtask
   task rd(input [5:0] a, input [31:0] s);
      i_rd <= 1'b1;
      i_addr <= a;
      i_wdata <= s;
      @(posedge i_clk);
      i_rd <= 1'b0;
      @(posedge i_clk);
      d = o_rdata;
   endtask
   task rc(input [5:0] a, input [31:0] s, input [31:0] e);
      rd(a, s);
      chk($sformatf("rdata_%h", a), e, d);
   endtask
   task wait_idle;
      // stale read data must not end the wait before one status read
      d = 32'h1;
      for (w = 0; w < 100 && d[0] !== 1'b0; w = w + 1) rd(`IOCT_A_ADC_STAT, 0);
      if (w == 100) begin
         mismatches = mismatches + 1;
         stop_test;
      end
   endtask
   task pulse(input integer ln, input integer n);
      repeat (n) begin
         i_din[ln] <= 1'b1;
         repeat (2) @(posedge i_clk);
         i_din[ln] <= 1'b0;
         repeat (2) @(posedge i_clk);
      end
   endtask
   task dac(input [31:0] v, input [15:0] e);
      wr(`IOCT_A_DAC1, v);
      chk("o_dac1", e, o_dac1);
      wr(`IOCT_A_DAC2, v);
      chk("o_dac2", e, o_dac2);
   endtask
   initial begin
      repeat (20000) @(posedge i_clk);
      mismatches = mismatches + 1;
      stop_test;
   end
   initial begin
      repeat (8) @(posedge i_clk);
      i_rstn <= 1'b1;
      i_din <= 6'h2d;
      repeat (3) @(posedge i_clk);
      chk("o_dac1", 32'h8000, o_dac1);
      rc(`IOCT_A_DIN_ALL, 0, 32'h2d);
      for (k = 0; k < 6; k = k + 1) rc(`IOCT_A_DIN_ONE, k, (32'h2d >> k) & 32'h1);
      rc(6'h3f, 0, 32'h0);
      wr(`IOCT_A_DOUT_ALL, 32'h15);
      chk("o_dout", 32'h15, o_dout);
      wr(`IOCT_A_DOUT_HIGH, 32'h1);
      chk("o_dout", 32'h17, o_dout);
      wr(`IOCT_A_DOUT_LOW, 32'h4);
      rc(`IOCT_A_DOUT_ALL, 0, 32'h07);
      i_trig <= 1'b0;
      repeat (4) @(posedge i_clk);
      i_trig <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_trig <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_trig <= 1'b1;
      repeat (3) @(posedge i_clk);
      chk("trig_n", 32'h2, trig_n);
      i_din <= 6'h0;
      wr(`IOCT_A_CNT_EN, 32'h1);
      wr(`IOCT_A_CNT_CLR, 32'h3);
      pulse(4, 5);
      pulse(5, 3);
      wr(`IOCT_A_CNT_LAT, 32'h3);
      rc(`IOCT_A_LATCH1, 0, 32'h5);
      rc(`IOCT_A_LATCH2, 0, 32'h0);
      wr(`IOCT_A_CNT_EN, 32'h3);
      pulse(4, 2);
      pulse(5, 3);
      i_din <= 6'h30;
      repeat (4) @(posedge i_clk);
      rc(`IOCT_A_DIN_ONE, 4, 32'h1);
      rc(`IOCT_A_DIN_ALL, 0, 32'h30);
      wr(`IOCT_A_CNT_LAT, 32'h1);
      rc(`IOCT_A_LATCH1, 0, 32'h8);
      rc(`IOCT_A_LATCH2, 0, 32'h0);
      wr(`IOCT_A_CNT_LAT, 32'h2);
      rc(`IOCT_A_LATCH2, 0, 32'h4);
      i_din <= 6'h0;
      wr(`IOCT_A_CNT_CLR, 32'h1);
      pulse(4, 1);
      wr(`IOCT_A_CNT_LAT, 32'h3);
      rc(`IOCT_A_LATCH1, 0, 32'h1);
      rc(`IOCT_A_LATCH2, 0, 32'h4);
      dac(32'h0000abcd, 16'habcd);
      dac(32'h00010000, 16'hffff);
      dac(32'hffffffff, 16'h0000);
      dac(32'h80000000, 16'h0000);
      dac(32'h7fffffff, 16'hffff);
      wr(`IOCT_A_MUX, 32'h3);
      chk("o_mux_sel", 32'h3, o_mux_sel);
      wr(`IOCT_A_ADC_CTRL, 32'h1);
      wait_idle;
      rc(`IOCT_A_ADC_DATA, 0, 32'h6000);
      slow <= 1'b0;
      wr(`IOCT_A_MUX, 32'h7);
      wr(`IOCT_A_ADC_CTRL, 32'h3);
      // fast count is over here, the standard count would still be busy
      repeat (6) @(posedge i_clk);
      rc(`IOCT_A_ADC_STAT, 0, 32'h0);
      wait_idle;
      rc(`IOCT_A_ADC_DATA, 0, 32'hffff);
      wr(`IOCT_A_SEQ_SEL, 32'h81);
      wr(`IOCT_A_ADC_CTRL, 32'h1);
      wait_idle;
      for (k = 0; k < 8; k = k + 1) begin
         rd(`IOCT_A_SEQ_READ, 0);
         if (k == 0 || k == 7) chk("seq_result", (k == 7) ? 32'hffff : 32'h0, d);
      end
      stop_test;
   end
endmodule
